// File: design/lbm_pkg.sv
// Constants, types and register map for the local bus master interface
//
// Functional notes
// - Bus request rises only between bus cycles, never inside one.
// - Normally bus request drops before the grant input falls.
// - Grant lost while owning: request drops within 4 clocks word, 8 byte.
// - Grant input is synchronised; host drops grant after seeing request low.
// - Attention strobe synchronised, caught on falling edge, starts command fetch.
// - Upper byte enable low for 16-bit bus, high for 8-bit bus.
// - After reset the data bus is 8 bits wide.
// - While effective ready is low, wait states are inserted.
// - Effective ready is dedicated ready OR configurable ready; dedicated only maximum mode.
// - Configurable ready: synchronous as-is, asynchronous synchronises only its rising edge.
// - After reset the configurable ready is treated as asynchronous.
// - Status codes: 00 unused, 01 read, 10 write, 11 passive.
// - Status active through t2, passive from t3 and in wait states.
// - Each memory cycle starts by leaving the passive status code.
// - Status pulled high and floated after reset and when bus not owned.
// - Minimum mode read strobe low in t2, t3 and wait states of reads.
// - Read strobe pulled high and floated after reset and when not owning.
package lbm_pkg;
    // =========================================================
    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD  = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_CYC  = 8'h0C;
    // Field positions
    localparam int CTRL_WIDE   = 0;
    localparam int CTRL_SYNC   = 1;
    localparam int CMD_GO      = 0;
    localparam int CMD_WRITE   = 1;
    localparam int CMD_CNT_LSB = 4;
    localparam int STAT_ATTN   = 2;
    // Values after reset: 8-bit bus, asynchronous ready
    localparam logic [1:0] CTRL_RST = 2'h0;
    // Forced release limits in clocks
    localparam int DROP_WORD_CLK = 4;
    localparam int DROP_BYTE_CLK = 8;
    // Cycle status codes {high, low}
    localparam logic [1:0] CODE_READ    = 2'h1;
    localparam logic [1:0] CODE_WRITE   = 2'h2;
    localparam logic [1:0] CODE_PASSIVE = 2'h3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Synchroniser lanes
    localparam int PIN_GRANT = 0;
    localparam int PIN_ATTN  = 1;
    localparam int PIN_MODE  = 2;
    localparam int PIN_SYNC_READY_IN  = 3;
    localparam int PIN_ASYNC_READY_IN  = 4;
    localparam int PIN_CNT   = 5;

    typedef enum logic [2:0] {
        ST_IDLE, ST_REQ, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_REL
    } lbm_state_t;
endpackage : lbm_pkg

// File: design/lbm_sync_if.sv
// Carrier between the pin synchroniser and the bus master core
`timescale 1ns/1ps
interface lbm_sync_if #(parameter int W = 5);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport core (output raw, input synced);
    modport sync (input raw, output synced);
endinterface : lbm_sync_if

// File: design/lbm_sync.sv
// Two-stage synchroniser for the asynchronous input pins
`timescale 1ns/1ps
module lbm_sync #(
    parameter int W = 5
) (
    input wire logic mclk,
    input wire logic reset,
    lbm_sync_if.sync pins
);
    logic [W-1:0] meta_q;
    logic [W-1:0] hold_q;

    // First stage feeds only the second
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            hold_q <= '0;
        end else begin
            meta_q <= pins.raw;
            hold_q <= meta_q;
        end
    end

    assign pins.synced = hold_q;
endmodule : lbm_sync

// File: design/lbm_master.sv
// Local bus master core: hold/grant handshake, cycle sequencer, AXI4-Lite slave
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module lbm_master
    import lbm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    // Local bus pins
    input  wire logic        bus_grant_in,
    input  wire logic        attention_strobe,
    input  wire logic        bus_mode_select,
    input  wire logic        sync_ready_in,
    input  wire logic        async_ready_in,
    output logic             bus_request,
    output logic             upper_byte_enable_n,
    output logic             upper_byte_enable_oe,
    output logic             cycle_status_high,
    output logic             cycle_status_low,
    output logic             cycle_status_oe,
    output logic             read_strobe_n,
    output logic             read_strobe_oe,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // =========================================================
    // Pin synchronisation
    lbm_sync_if #(.W(PIN_CNT)) pins_if ();

    assign pins_if.raw = {async_ready_in, sync_ready_in, bus_mode_select,
                          attention_strobe, bus_grant_in};

    lbm_sync #(.W(PIN_CNT)) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .pins  (pins_if.sync)
    );

    wire grant_s = pins_if.synced[PIN_GRANT];
    wire attn_s  = pins_if.synced[PIN_ATTN];
    wire min_s   = pins_if.synced[PIN_MODE];
    wire sync_ready_in_s  = pins_if.synced[PIN_SYNC_READY_IN];
    wire async_ready_in_s  = pins_if.synced[PIN_ASYNC_READY_IN];

    // =========================================================
    // Registers and state
    lbm_state_t  state_q, state_d;
    logic [1:0]  ctrl_q;
    logic        cmd_write_q;
    logic [3:0]  cmd_cnt_q;
    logic [3:0]  rem_q;
    logic        start_q;
    logic        attn_prev_q;
    logic        attn_pend_q;
    logic        async_ready_in_late_q;
    logic [15:0] cyc_q;

    // =========================================================
    // Effective ready
    // Extra stage delays only the rising edge; a falling edge stops at once
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) async_ready_in_late_q <= 1'b0;
        else       async_ready_in_late_q <= async_ready_in_s;
    end

    wire cfg_rdy = ctrl_q[CTRL_SYNC] ? async_ready_in_s : (async_ready_in_s & async_ready_in_late_q);
    wire ded_rdy = ~min_s & sync_ready_in_s;
    wire rdy     = cfg_rdy | ded_rdy;

    a_ready_or: assert property (
        (state_q == ST_TW && !min_s && sync_ready_in_s) |=> state_q != ST_TW)
        else $error("dedicated ready ignored in maximum mode");

    // =========================================================
    // Attention strobe: caught on its falling edge
    wire attn_fall = attn_prev_q & ~attn_s;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) attn_prev_q <= 1'b0;
        else       attn_prev_q <= attn_s;
    end

    a_attn_latch: assert property (
        attn_fall |=> attn_pend_q && start_q)
        else $error("attention falling edge not latched");

    // =========================================================
    // AXI4-Lite write path and decode
    logic aw_rdy_q, b_vld_q, ar_rdy_q, r_vld_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;

    wire wr_go    = s_axi_awvalid & s_axi_wvalid & ~aw_rdy_q & ~b_vld_q;
    wire wr_take  = aw_rdy_q;
    wire lane0    = s_axi_wstrb[0];
    wire wr_ctrl  = wr_take & (s_axi_awaddr == REG_CTRL) & lane0;
    wire wr_cmd   = wr_take & (s_axi_awaddr == REG_CMD) & lane0;
    wire wr_stat  = wr_take & (s_axi_awaddr == REG_STAT) & lane0;
    wire wr_map   = (s_axi_awaddr == REG_CTRL) | (s_axi_awaddr == REG_CMD)
                  | (s_axi_awaddr == REG_STAT) | (s_axi_awaddr == REG_CYC);
    wire cmd_go   = wr_cmd & s_axi_wdata[CMD_GO];
    wire attn_clr = wr_stat & s_axi_wdata[STAT_ATTN];

    // Address and data are taken together, one cycle after both are offered
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_rdy_q <= 1'b0;
            b_vld_q  <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else begin
            aw_rdy_q <= wr_go;
            if (wr_take) begin
                b_vld_q <= 1'b1;
                bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                b_vld_q <= 1'b0;
            end
        end
    end

    // Control and command registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q      <= CTRL_RST;
            cmd_write_q <= 1'b0;
            cmd_cnt_q   <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= s_axi_wdata[1:0];
            if (wr_cmd) begin
                cmd_write_q <= s_axi_wdata[CMD_WRITE];
                cmd_cnt_q   <= s_axi_wdata[CMD_CNT_LSB +: 4];
            end
        end
    end

    // Pending flags: a new event beats a clear in the same cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            attn_pend_q <= 1'b0;
            start_q     <= 1'b0;
        end else begin
            attn_pend_q <= attn_fall | (attn_pend_q & ~attn_clr);
            start_q     <= cmd_go | attn_fall | (start_q & (state_q != ST_IDLE));
        end
    end

    // =========================================================
    // AXI4-Lite read path
    wire rd_go = s_axi_arvalid & ~ar_rdy_q & ~r_vld_q;
    wire own_q;
    wire [31:0] stat_word = {27'h0, min_s, attn_pend_q,
                             (state_q != ST_IDLE), grant_s, own_q};
    wire rd_map = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_CMD)
                | (s_axi_araddr == REG_STAT) | (s_axi_araddr == REG_CYC);
    wire [31:0] rd_mux =
        (s_axi_araddr == REG_CTRL) ? {30'h0, ctrl_q} :
        (s_axi_araddr == REG_CMD)  ? {24'h0, cmd_cnt_q, 2'h0, cmd_write_q, 1'b0} :
        (s_axi_araddr == REG_STAT) ? stat_word :
        (s_axi_araddr == REG_CYC)  ? {16'h0, cyc_q} : 32'h0;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ar_rdy_q <= 1'b0;
            r_vld_q  <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else begin
            ar_rdy_q <= rd_go;
            if (ar_rdy_q) begin
                r_vld_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                r_vld_q <= 1'b0;
            end
        end
    end

    // =========================================================
    // Cycle sequencer
    wire in_cycle = (state_q == ST_T1) | (state_q == ST_T2) | (state_q == ST_T3)
                  | (state_q == ST_TW) | (state_q == ST_T4);
    wire more     = (rem_q != 4'h0);

    // Loss of grant abandons the cycle so the request drops next clock
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (start_q) state_d = ST_REQ;
            ST_REQ:  if (grant_s) state_d = ST_T1;
            ST_T1:   state_d = grant_s ? ST_T2 : ST_REL;
            ST_T2:   state_d = grant_s ? ST_T3 : ST_REL;
            ST_T3:   state_d = !grant_s ? ST_REL : (rdy ? ST_T4 : ST_TW);
            ST_TW:   state_d = !grant_s ? ST_REL : (rdy ? ST_T4 : ST_TW);
            ST_T4:   state_d = (grant_s && more) ? ST_T1 : ST_REL;
            ST_REL:  if (!grant_s) state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            rem_q   <= '0;
            cyc_q   <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE) rem_q <= cmd_cnt_q;
            else if (state_q == ST_T4 && more) rem_q <= rem_q - 4'h1;
            if (state_q == ST_T4) cyc_q <= cyc_q + 16'h1;
        end
    end

    // Grant held through t1 and t2, so no abandon can cut the head short
    sequence s_grant_two;
        (state_q == ST_T1 && grant_s) ##1 grant_s;
    endsequence

    sequence s_head;
        state_q == ST_T2 ##1 state_q == ST_T3;
    endsequence

    a_cycle_order: assert property (
        s_grant_two |-> s_head)
        else $error("memory cycle left t1-t2-t3 order");

    a_wait_hold: assert property (
        (state_q inside {ST_T3, ST_TW} && grant_s && !rdy) |=> state_q == ST_TW)
        else $error("cycle advanced while not ready");

    // =========================================================
    // Pin outputs, all from flip-flops
    logic req_q, ube_n_q, ube_oe_q, st_hi_q, st_lo_q, st_oe_q, rd_n_q, rd_oe_q;

    wire own_d   = (state_d == ST_T1) | (state_d == ST_T2) | (state_d == ST_T3)
                 | (state_d == ST_TW) | (state_d == ST_T4);
    wire req_d   = (state_d == ST_REQ) | own_d;
    wire code_on = (state_d == ST_T1) | (state_d == ST_T2);
    wire [1:0] code = cmd_write_q ? CODE_WRITE : CODE_READ;
    wire [1:0] st_d = code_on ? code : CODE_PASSIVE;
    wire rd_on   = ~cmd_write_q & ((state_d == ST_T2) | (state_d == ST_T3)
                 | (state_d == ST_TW));

    // Not owning: codes parked high and drivers released
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            req_q    <= 1'b0;
            ube_n_q  <= 1'b1;
            ube_oe_q <= 1'b0;
            st_hi_q  <= 1'b1;
            st_lo_q  <= 1'b1;
            st_oe_q  <= 1'b0;
            rd_n_q   <= 1'b1;
            rd_oe_q  <= 1'b0;
        end else begin
            req_q    <= req_d;
            ube_n_q  <= ~ctrl_q[CTRL_WIDE];
            ube_oe_q <= own_d;
            st_hi_q  <= st_d[1];
            st_lo_q  <= st_d[0];
            st_oe_q  <= own_d & ~min_s;
            rd_n_q   <= ~(rd_on & min_s);
            rd_oe_q  <= own_d & min_s;
        end
    end

    assign own_q = st_oe_q | rd_oe_q;

    a_req_rise_idle: assert property (
        $rose(req_q) |-> $past(state_q) == ST_IDLE)
        else $error("request raised inside a bus cycle");

    a_req_before_grant: assert property (
        (state_q == ST_T4 && !more && grant_s) |=> !req_q)
        else $error("request not dropped at end of burst");

    a_req_drop_word: assert property (
        ($fell(grant_s) && in_cycle && ctrl_q[CTRL_WIDE]) |-> ##[1:4] !req_q)
        else $error("request held too long after grant loss, word mode");

    a_req_drop_byte: assert property (
        ($fell(grant_s) && in_cycle && !ctrl_q[CTRL_WIDE]) |-> ##[1:8] !req_q)
        else $error("request held too long after grant loss, byte mode");

    a_ube_width: assert property (
        ##1 ube_n_q == !$past(ctrl_q[CTRL_WIDE]))
        else $error("upper byte enable does not follow bus width");

    a_status_t3: assert property (
        (state_q == ST_T3) |-> {st_hi_q, st_lo_q} == CODE_PASSIVE)
        else $error("status not passive in t3");

    a_status_float: assert property (
        (!in_cycle) |-> !st_oe_q && st_hi_q && st_lo_q)
        else $error("status driven while bus not owned");

    a_read_strobe: assert property (
        (state_q inside {ST_T2, ST_T3, ST_TW} && min_s && !cmd_write_q)
        |-> !rd_n_q && rd_oe_q)
        else $error("read strobe not low during read cycle");

    a_read_float: assert property (
        (!in_cycle) |-> rd_n_q && !rd_oe_q)
        else $error("read strobe driven while bus not owned");

    // =========================================================
    // Output drive
    assign bus_request          = req_q;
    assign upper_byte_enable_n  = ube_n_q;
    assign upper_byte_enable_oe = ube_oe_q;
    assign cycle_status_high    = st_hi_q;
    assign cycle_status_low     = st_lo_q;
    assign cycle_status_oe      = st_oe_q;
    assign read_strobe_n        = rd_n_q;
    assign read_strobe_oe       = rd_oe_q;
    assign s_axi_awready        = aw_rdy_q;
    assign s_axi_wready         = aw_rdy_q;
    assign s_axi_bvalid         = b_vld_q;
    assign s_axi_bresp          = bresp_q;
    assign s_axi_arready        = ar_rdy_q;
    assign s_axi_rvalid         = r_vld_q;
    assign s_axi_rdata          = rdata_q;
    assign s_axi_rresp          = rresp_q;
endmodule : lbm_master

// File: tb/lbm_host.sv
// Host CPU and slow memory model on the far side of the local bus
`timescale 1ns/1ps
module lbm_host
    import lbm_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       bus_request,
    input  wire logic       yank,
    input  wire logic [1:0] rdy_sel,
    input  wire logic [1:0] wait_cnt,
    output logic            bus_grant_in,
    output logic            sync_ready_in,
    output logic            async_ready_in
);
    logic [2:0] ph_q;
    logic       rdy;
    // =========================================================
    // Grant follows request one clock later and falls only after it, unless yank withdraws it first
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_grant_in <= 1'b0;
            ph_q         <= 3'h0;
        end else begin
            bus_grant_in <= bus_request && !yank;
            ph_q         <= (ph_q > {1'b0, wait_cnt}) ? 3'h0 : ph_q + 3'h1;
        end
    end
    // =========================================================
    // Ready low for wait_cnt clocks then high two clocks; low when not owned
    assign rdy            = bus_grant_in && (ph_q >= {1'b0, wait_cnt});
    assign sync_ready_in  = rdy && rdy_sel[1];
    assign async_ready_in = rdy && rdy_sel[0];
endmodule : lbm_host

// File: tb/tb_top.sv
// Self-checking bench for the local bus master
`timescale 1ns/1ps
module tb_top
    import lbm_pkg::*;
;
    logic mclk, reset, bus_grant_in, attention_strobe, bus_mode_select;
    logic sync_ready_in, async_ready_in, bus_request, upper_byte_enable_n;
    logic upper_byte_enable_oe, cycle_status_high, cycle_status_low;
    logic cycle_status_oe, read_strobe_n, read_strobe_oe, yank;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rv, rs;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, rdy_sel, wait_cnt, pcode;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic wide_e, p_oe, p_rd;
    int   fails, checks_done, falls, exp_cyc, k;
    logic [1:0] code_q[$];

    lbm_master lbm_master_i (.*);
    lbm_host lbm_host_i (.mclk, .reset, .bus_request, .yank, .rdy_sel, .wait_cnt,
        .bus_grant_in, .sync_ready_in, .async_ready_in);

    // =========================================================
    // Clock and common tasks
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // A hang ends the run rather than stalling the simulator
    task automatic tick();
        @(posedge mclk);
        k++;
        if (k > 3000) begin
            fails++;
            print_verdict();
        end
    endtask : tick
    // =========================================================
    // AXI4-Lite master: address and data offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        k = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            tick();
            if (s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do tick(); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        k = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do tick(); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) tick();
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr
    // Polls status until idle; each read restarts k, so the poll count is the bound
    task automatic wait_idle();
        int polls;
        polls = 0;
        do begin
            axr(REG_STAT);
            polls++;
            if (polls > 500) begin
                fails++;
                print_verdict();
            end
        end while (rv[2] !== 1'b0 || bus_request !== 1'b0);
    endtask : wait_idle
    // =========================================================
    // Bus monitor: cycle starts, read strobes, idle levels
    always @(posedge mclk) begin
        if (cycle_status_oe === 1'b1 && pcode == CODE_PASSIVE &&
            {cycle_status_high, cycle_status_low} != CODE_PASSIVE) begin
            code_q.push_back({cycle_status_high, cycle_status_low});
        end
        if (read_strobe_oe === 1'b1 && p_rd === 1'b1 && read_strobe_n === 1'b0) begin
            falls++;
        end
        if (upper_byte_enable_oe === 1'b1 && p_oe !== 1'b1) begin
            check(upper_byte_enable_n, !wide_e);
        end
        if (reset === 1'b0 && cycle_status_oe !== 1'b1 && read_strobe_oe !== 1'b1) begin
            check({cycle_status_high, cycle_status_low, read_strobe_n}, 3'h7);
        end
        pcode = {cycle_status_high, cycle_status_low};
        p_rd = read_strobe_n;
        p_oe = upper_byte_enable_oe;
    end
    // =========================================================
    // One burst: configure, start by command or attention, compare with model
    task automatic burst(input logic md, wd, sy, wr, at, st, input logic [3:0] n);
        bus_mode_select <= md;
        wide_e = wd;
        axw(REG_CTRL, {30'h0, sy, wd});
        check(resp, RESP_OKAY);
        repeat (3) @(posedge mclk);
        code_q.delete();
        falls = 0;
        if (at) begin
            attention_strobe <= 1'b1;
            repeat (2) @(posedge mclk);
            attention_strobe <= 1'b0;
        end else begin
            axw(REG_CMD, {24'h0, n, 2'h0, wr, 1'b1});
        end
        k = 0;
        while (bus_request !== 1'b1) tick();
        if (st) begin
            // Only the dedicated pin is ready; it must count for nothing here
            repeat (100) @(posedge mclk);
            axr(REG_CYC);
            check(rv, exp_cyc & 32'hFFFF);
            rdy_sel <= 2'h1;
        end
        wait_idle();
        if (at) begin
            // Pending attention stays set until software clears it
            axr(REG_STAT);
            check(rv[3], 1'b1);
            axw(REG_STAT, 32'h4);
            axr(REG_STAT);
            check(rv[3], 1'b0);
        end
        exp_cyc += n + 1;
        axr(REG_CYC);
        check(rv, exp_cyc & 32'hFFFF);
        if (!md) begin
            check(code_q.size(), n + 1);
            foreach (code_q[i]) check(code_q[i], wr ? CODE_WRITE : CODE_READ);
        end else begin
            check(falls, wr ? 0 : n + 1);
        end
    endtask : burst
    // =========================================================
    // Main sequence
    initial begin
        {reset, bus_mode_select, yank, attention_strobe} = 4'h8;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        rdy_sel = 2'h1;
        wait_cnt = 2'h0;
        seed = 32'h3ACD5DB9;
        {fails, checks_done, exp_cyc, falls, k} = 0;
        {wide_e, p_oe, p_rd, pcode} = 5'h1F;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check({bus_request, cycle_status_oe, read_strobe_oe, upper_byte_enable_oe}, 0);
        // A write with lane 0 off must leave the control register alone
        s_axi_wstrb <= 4'hE;
        axw(REG_CTRL, 32'h3);
        check(resp, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axr(REG_CTRL);
        check(rv, 32'h0);
        axr(8'h10);
        check(resp, RESP_SLVERR);
        axw(8'h10, 32'h0);
        check(resp, RESP_SLVERR);
        // Own copy of the random word: register reads overwrite rv
        for (int i = 0; i < 8; i++) begin
            rs = rnd();
            wait_cnt <= rs[1:0];
            rdy_sel <= i[0] ? 2'h1 : ((rs[9:8] == 2'h0) ? 2'h2 : rs[9:8]);
            burst(i[0], i[1], rs[4], i[2], 1'b0, 1'b0, rs[7:4]);
            if (i == 7) begin
                burst(i[0], i[1], rs[4], i[2], 1'b1, 1'b0, rs[7:4]);
            end
        end
        rdy_sel <= 2'h2;
        burst(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h2);
        // Withdrawn grant forces the request off within the mode's limit
        for (int w = 0; w < 2; w++) begin
            wait_cnt <= 2'h3;
            bus_mode_select <= 1'b0;
            wide_e = w[0];
            axw(REG_CTRL, {30'h0, 1'b0, w[0]});
            axw(REG_CMD, 32'hF1);
            k = 0;
            while (bus_request !== 1'b1 || cycle_status_oe !== 1'b1) tick();
            repeat (3) @(posedge mclk);
            yank <= 1'b1;
            @(posedge mclk);
            k = 0;
            do tick(); while (bus_request !== 1'b0);
            check(k <= (w ? DROP_WORD_CLK : DROP_BYTE_CLK), 1);
            yank <= 1'b0;
            wait_idle();
        end
        print_verdict();
    end
endmodule : tb_top
